//--- src/erp_defs.vh
// constants for the error recovery policy controller
// assumes a 250 MHz mclk; times are held in picoseconds
`ifndef ERP_DEFS_VH
`define ERP_DEFS_VH
`define ERP_CLK_PS 4000
`define ERP_MS_PS 1000000000
`define ERP_TENTH_PS 100000000
`define ERP_READ_LEVELS 4'hc
`define ERP_WRITE_LEVELS 4'h5
`define ERP_RD_RETRY_MAX 8'h0c
`define ERP_WR_RETRY_MAX 8'h05
`define ERP_LIMIT_DFLT 16'hffff
`define ERP_LIMIT_ZERO 16'h0000
// per-block budgets in tenths of a millisecond
`define ERP_RD_T0 16'h0397
`define ERP_RD_T1 16'h043f
`define ERP_RD_T2 16'h04e6
`define ERP_RD_T3 16'h0634
`define ERP_RD_T4 16'h082a
`define ERP_RD_T5 16'h0ac7
`define ERP_RD_T6 16'h0d64
`define ERP_RD_T7 16'h124a
`define ERP_RD_T8 16'h158e
`define ERP_RD_T9 16'h182a
`define ERP_RD_T10 16'h1e0b
`define ERP_RD_T11 16'h5713
`define ERP_RD_T12 16'hc0bb
`define ERP_WR_T0 16'h01f5
`define ERP_WR_T1 16'h02f0
`define ERP_WR_T2 16'h0344
`define ERP_WR_T3 16'h043f
`define ERP_WR_T4 16'h0a1f
`define ERP_WR_T5 16'h0c69
`endif

//--- src/erp_rtimer.v
// saturating recovery timer with its own prescaler
// assumes clr and run come from the same mclk domain
`timescale 1ns/1ps
module erp_rtimer #(
    parameter TICK_CYC = 250000,
    parameter W = 16
) (
    // clock and reset
    input wire mclk,
    input wire rst_b,
    // control
    input wire clr,
    input wire run,
    // elapsed units
    output reg [W-1:0] count
);
    localparam [31:0] TOP = TICK_CYC - 1;
    reg [31:0] pre_reg;

    // prescaler only moves while running, so paused time is never counted
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pre_reg <= 32'h0;
            count <= {W{1'b0}};
        end else if (clr) begin
            pre_reg <= 32'h0;
            count <= {W{1'b0}};
        end else if (run) begin
            if (pre_reg == TOP) begin
                pre_reg <= 32'h0;
                if (count != {W{1'b1}}) begin
                    count <= count + 1'b1;
                end
            end else begin
                pre_reg <= pre_reg + 32'h1;
            end
        end
    end
endmodule

//--- src/erp_ctrl.v
// error recovery policy controller: retries, time limits, reallocation,
// factory and grown defect lists with a readout stream
// assumes one mclk domain; media engine answers step and reallocate requests
`timescale 1ns/1ps
`include "erp_defs.vh"
module erp_ctrl #(
    parameter ADDR_W = 32,
    parameter PL_DEPTH = 16,
    parameter PL_AW = 4,
    parameter GL_DEPTH = 16,
    parameter GL_AW = 4,
    parameter MS_CYC = `ERP_MS_PS / `ERP_CLK_PS,
    parameter TENTH_CYC = `ERP_TENTH_PS / `ERP_CLK_PS
) (
    // clock and reset
    input wire mclk,
    input wire rst_b,
    // recovery page settings
    input wire auto_read_reallocate_en,
    input wire auto_write_reallocate_en,
    input wire read_continuous,
    input wire [7:0] read_retry_cnt,
    input wire [7:0] write_retry_cnt,
    input wire [15:0] recovery_time_limit,
    // command framing
    input wire cmd_start,
    input wire cmd_is_write,
    input wire cmd_end,
    // per-block media results
    input wire blk_valid,
    input wire [ADDR_W-1:0] blk_addr,
    input wire blk_error,
    output wire blk_ready,
    output reg blk_pass,
    output reg [ADDR_W-1:0] blk_pass_addr,
    // recovery step handshake with media engine
    output reg rcv_req,
    output reg [3:0] rcv_level,
    output reg rcv_abort,
    input wire rcv_done,
    input wire rcv_ok,
    // reallocation handshake
    output reg realloc_req,
    output reg [ADDR_W-1:0] realloc_addr,
    input wire realloc_done,
    // command status
    output reg xfer_halt,
    output reg chk_cond,
    output reg err_unrec_read,
    output reg err_unrec_write,
    output wire [15:0] cmd_rcv_ms,
    // factory defect table load
    input wire factory_defect_table_wr,
    input wire [ADDR_W-1:0] factory_defect_table_addr,
    input wire factory_fmt_done,
    output reg factory_locked,
    output reg [PL_AW:0] pl_count,
    output reg [GL_AW:0] gl_count,
    // defect data readout
    input wire dl_start,
    output reg dl_busy,
    output reg dl_valid,
    output reg [ADDR_W-1:0] dl_data,
    output reg dl_grown,
    output reg dl_done
);
    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_READY = 6'h02;
    localparam [5:0] S_STEP = 6'h04;
    localparam [5:0] S_WAIT = 6'h08;
    localparam [5:0] S_REALLOC = 6'h10;
    localparam [5:0] S_HALT = 6'h20;

    reg [5:0] st_reg;
    reg wr_reg;
    reg rd_cont_reg;
    reg ar_reg;
    reg aw_reg;
    reg [7:0] retry_reg;
    reg [15:0] lim_reg;
    reg [15:0] budget_reg;
    reg [ADDR_W-1:0] cur_addr_reg;
    reg [ADDR_W-1:0] pl_mem [0:PL_DEPTH-1];
    reg [ADDR_W-1:0] gl_mem [0:GL_DEPTH-1];
    reg dl_grp_reg;
    reg [GL_AW:0] dl_idx_reg;
    wire [15:0] blk_tenths;
    wire rcv_run;
    wire cmd_out;
    wire blk_out;
    wire [3:0] max_level;
    wire realloc_ok;
    wire gl_full;
    wire [15:0] lim_eff;
    wire [7:0] retry_sel;

    // per-block budget in tenths of a millisecond, clamped at the top entry
    function [15:0] erp_budget;
        input wr;
        input [7:0] cnt;
        begin
            if (wr) begin
                case ((cnt > `ERP_WR_RETRY_MAX) ? `ERP_WR_RETRY_MAX : cnt)
                    8'h00: erp_budget = `ERP_WR_T0;
                    8'h01: erp_budget = `ERP_WR_T1;
                    8'h02: erp_budget = `ERP_WR_T2;
                    8'h03: erp_budget = `ERP_WR_T3;
                    8'h04: erp_budget = `ERP_WR_T4;
                    default: erp_budget = `ERP_WR_T5;
                endcase
            end else begin
                case ((cnt > `ERP_RD_RETRY_MAX) ? `ERP_RD_RETRY_MAX : cnt)
                    8'h00: erp_budget = `ERP_RD_T0;
                    8'h01: erp_budget = `ERP_RD_T1;
                    8'h02: erp_budget = `ERP_RD_T2;
                    8'h03: erp_budget = `ERP_RD_T3;
                    8'h04: erp_budget = `ERP_RD_T4;
                    8'h05: erp_budget = `ERP_RD_T5;
                    8'h06: erp_budget = `ERP_RD_T6;
                    8'h07: erp_budget = `ERP_RD_T7;
                    8'h08: erp_budget = `ERP_RD_T8;
                    8'h09: erp_budget = `ERP_RD_T9;
                    8'h0a: erp_budget = `ERP_RD_T10;
                    8'h0b: erp_budget = `ERP_RD_T11;
                    default: erp_budget = `ERP_RD_T12;
                endcase
            end
        end
    endfunction

    // timers only run while a recovery step is in flight
    assign rcv_run = st_reg[3];
    assign blk_ready = st_reg[1];
    assign lim_eff = (recovery_time_limit == `ERP_LIMIT_ZERO) ? `ERP_LIMIT_DFLT
                     : recovery_time_limit;
    assign retry_sel = cmd_is_write ? write_retry_cnt : read_retry_cnt;
    assign cmd_out = (cmd_rcv_ms >= lim_reg);
    assign blk_out = (blk_tenths >= budget_reg);
    assign max_level = wr_reg ? `ERP_WRITE_LEVELS : `ERP_READ_LEVELS;
    assign gl_full = (gl_count == GL_DEPTH[GL_AW:0]);
    // read-continuous alone blocks reallocation; writes ignore it
    assign realloc_ok = (wr_reg ? aw_reg : (ar_reg && !rd_cont_reg))
                        && !cmd_out && !gl_full;

    // command timer: cleared at each command start
    erp_rtimer #(.TICK_CYC(MS_CYC), .W(16)) u_cmd_tmr (
        .mclk(mclk),
        .rst_b(rst_b),
        .clr(cmd_start),
        .run(rcv_run),
        .count(cmd_rcv_ms)
    );

    // per-block timer: finer grain to honour the tenth-ms budgets
    erp_rtimer #(.TICK_CYC(TENTH_CYC), .W(16)) u_blk_tmr (
        .mclk(mclk),
        .rst_b(rst_b),
        .clr(st_reg[1]),
        .run(rcv_run),
        .count(blk_tenths)
    );

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= S_IDLE;
            wr_reg <= 1'b0;
            rd_cont_reg <= 1'b0;
            ar_reg <= 1'b0;
            aw_reg <= 1'b0;
            retry_reg <= 8'h00;
            lim_reg <= `ERP_LIMIT_DFLT;
            budget_reg <= 16'h0000;
            cur_addr_reg <= {ADDR_W{1'b0}};
            blk_pass <= 1'b0;
            blk_pass_addr <= {ADDR_W{1'b0}};
            rcv_req <= 1'b0;
            rcv_level <= 4'h0;
            rcv_abort <= 1'b0;
            realloc_req <= 1'b0;
            realloc_addr <= {ADDR_W{1'b0}};
            xfer_halt <= 1'b0;
            chk_cond <= 1'b0;
            err_unrec_read <= 1'b0;
            err_unrec_write <= 1'b0;
            gl_count <= {(GL_AW+1){1'b0}};
        end else begin
            blk_pass <= 1'b0;
            rcv_req <= 1'b0;
            rcv_abort <= 1'b0;
            realloc_req <= 1'b0;
            if (cmd_start) begin
                // settings are frozen per command so a mid-command change is harmless
                st_reg <= S_READY;
                wr_reg <= cmd_is_write;
                rd_cont_reg <= read_continuous;
                ar_reg <= auto_read_reallocate_en;
                aw_reg <= auto_write_reallocate_en;
                retry_reg <= retry_sel;
                budget_reg <= erp_budget(cmd_is_write, retry_sel);
                lim_reg <= lim_eff;
                xfer_halt <= 1'b0;
                chk_cond <= 1'b0;
                err_unrec_read <= 1'b0;
                err_unrec_write <= 1'b0;
            end else begin
                case (st_reg)
                    S_IDLE: begin
                        st_reg <= S_IDLE;
                    end
                    S_READY: begin
                        if (cmd_end) begin
                            st_reg <= S_IDLE;
                        end else if (blk_valid) begin
                            cur_addr_reg <= blk_addr;
                            if (!blk_error || (!wr_reg && rd_cont_reg)) begin
                                // erroneous data flows on with no retry and no flag
                                blk_pass <= 1'b1;
                                blk_pass_addr <= blk_addr;
                            end else if (retry_reg == 8'h00 || cmd_out) begin
                                st_reg <= S_HALT;
                                xfer_halt <= 1'b1;
                                chk_cond <= 1'b1;
                                err_unrec_read <= !wr_reg;
                                err_unrec_write <= wr_reg;
                            end else begin
                                st_reg <= S_STEP;
                                rcv_level <= 4'h1;
                            end
                        end
                    end
                    S_STEP: begin
                        rcv_req <= 1'b1;
                        st_reg <= S_WAIT;
                    end
                    S_WAIT: begin
                        if (rcv_done && rcv_ok) begin
                            blk_pass <= 1'b1;
                            blk_pass_addr <= cur_addr_reg;
                            if (realloc_ok) begin
                                st_reg <= S_REALLOC;
                                realloc_req <= 1'b1;
                                realloc_addr <= cur_addr_reg;
                            end else begin
                                st_reg <= S_READY;
                            end
                        end else if (rcv_done && rcv_level != max_level && !cmd_out && !blk_out) begin
                            rcv_level <= rcv_level + 4'h1;
                            st_reg <= S_STEP;
                        end else if (rcv_done || cmd_out || blk_out) begin
                            // stop at the last good block; nothing of this one is passed
                            rcv_abort <= !rcv_done;
                            st_reg <= S_HALT;
                            xfer_halt <= 1'b1;
                            chk_cond <= 1'b1;
                            err_unrec_read <= !wr_reg;
                            err_unrec_write <= wr_reg;
                        end
                    end
                    S_REALLOC: begin
                        if (realloc_done) begin
                            if (!gl_full) begin
                                gl_count <= gl_count + 1'b1;
                            end
                            st_reg <= S_READY;
                        end
                    end
                    S_HALT: begin
                        if (cmd_end) begin
                            st_reg <= S_IDLE;
                        end
                    end
                    default: begin
                        st_reg <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // grown list storage; written on the same edge that bumps the count
    always @(posedge mclk) begin
        if (st_reg[4] && realloc_done && !cmd_start && !gl_full) begin
            gl_mem[gl_count[GL_AW-1:0]] <= cur_addr_reg;
        end
    end

    // factory list: writable only until the format completes, then frozen
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            factory_locked <= 1'b0;
            pl_count <= {(PL_AW+1){1'b0}};
        end else begin
            if (factory_fmt_done) begin
                factory_locked <= 1'b1;
            end
            if (factory_defect_table_wr && !factory_locked && !factory_fmt_done
                && pl_count != PL_DEPTH[PL_AW:0]) begin
                pl_count <= pl_count + 1'b1;
            end
        end
    end

    always @(posedge mclk) begin
        if (factory_defect_table_wr && !factory_locked && !factory_fmt_done
            && pl_count != PL_DEPTH[PL_AW:0]) begin
            pl_mem[pl_count[PL_AW-1:0]] <= factory_defect_table_addr;
        end
    end

    // defect readout: factory entries first, then grown, one per cycle;
    // one idle cycle sits between the two groups
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dl_busy <= 1'b0;
            dl_valid <= 1'b0;
            dl_data <= {ADDR_W{1'b0}};
            dl_grown <= 1'b0;
            dl_done <= 1'b0;
            dl_grp_reg <= 1'b0;
            dl_idx_reg <= {(GL_AW+1){1'b0}};
        end else begin
            dl_valid <= 1'b0;
            dl_done <= 1'b0;
            if (!dl_busy) begin
                if (dl_start) begin
                    dl_busy <= 1'b1;
                    dl_grp_reg <= 1'b0;
                    dl_idx_reg <= {(GL_AW+1){1'b0}};
                end
            end else if (!dl_grp_reg) begin
                if (dl_idx_reg < pl_count) begin
                    dl_valid <= 1'b1;
                    dl_grown <= 1'b0;
                    dl_data <= pl_mem[dl_idx_reg[PL_AW-1:0]];
                    dl_idx_reg <= dl_idx_reg + 1'b1;
                end else begin
                    dl_grp_reg <= 1'b1;
                    dl_idx_reg <= {(GL_AW+1){1'b0}};
                end
            end else begin
                if (dl_idx_reg < gl_count) begin
                    dl_valid <= 1'b1;
                    dl_grown <= 1'b1;
                    dl_data <= gl_mem[dl_idx_reg[GL_AW-1:0]];
                    dl_idx_reg <= dl_idx_reg + 1'b1;
                end else begin
                    dl_busy <= 1'b0;
                    dl_done <= 1'b1;
                end
            end
        end
    end
endmodule

//--- tb/erp_props.sv
// property checker for the error recovery policy controller
// bound to erp_ctrl from the bench top; sees only its ports
`timescale 1ns/1ps
module erp_props #(
    parameter ADDR_W = 32,
    parameter PL_AW = 4,
    parameter GL_AW = 4
) (
    // clock and reset
    input wire mclk,
    input wire rst_b,
    // settings and framing
    input wire auto_read_reallocate_en,
    input wire auto_write_reallocate_en,
    input wire read_continuous,
    input wire [7:0] read_retry_cnt,
    input wire [7:0] write_retry_cnt,
    input wire [15:0] recovery_time_limit,
    input wire cmd_start,
    input wire cmd_is_write,
    // blocks and recovery
    input wire blk_valid,
    input wire [ADDR_W-1:0] blk_addr,
    input wire blk_error,
    input wire blk_ready,
    input wire blk_pass,
    input wire [ADDR_W-1:0] blk_pass_addr,
    input wire rcv_req,
    input wire [3:0] rcv_level,
    input wire realloc_req,
    input wire realloc_done,
    // status and lists
    input wire xfer_halt,
    input wire chk_cond,
    input wire err_unrec_read,
    input wire err_unrec_write,
    input wire [15:0] cmd_rcv_ms,
    input wire factory_locked,
    input wire [PL_AW:0] pl_count,
    input wire [GL_AW:0] gl_count
);
    // settings as captured at command start
    reg wr_q, rc_q, auto_read_reallocate_en_q, auto_write_reallocate_en_q, rp;
    reg [7:0] cnt_q;
    reg [15:0] lim_q;
    wire rd_rc = rc_q && !wr_q;
    wire acc = blk_valid && blk_ready && !cmd_start;
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            {wr_q, rc_q, auto_read_reallocate_en_q, auto_write_reallocate_en_q, rp, cnt_q} <= 0;
            lim_q <= 16'hffff;
        end else begin
            if (cmd_start) begin
                wr_q <= cmd_is_write;
                rc_q <= read_continuous;
                auto_read_reallocate_en_q <= auto_read_reallocate_en;
                auto_write_reallocate_en_q <= auto_write_reallocate_en;
                cnt_q <= cmd_is_write ? write_retry_cnt : read_retry_cnt;
                lim_q <= (recovery_time_limit == 16'h0000) ? 16'hffff : recovery_time_limit;
            end
            rp <= cmd_start ? 1'b0 : (realloc_req ? 1'b1 : (realloc_done ? 1'b0 : rp));
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_pass_clean: assert property (
        acc && (!blk_error || rd_rc) |=> blk_pass && blk_pass_addr == $past(blk_addr))
        else $error("clean block not passed");
    a_first_step: assert property (
        acc && blk_error && !rd_rc && cnt_q != 8'h00 && cmd_rcv_ms == 16'h0000 |-> ##2 rcv_req && rcv_level == 4'h1)
        else $error("first recovery step missing");
    a_zero_retry: assert property (
        acc && blk_error && !rd_rc && cnt_q == 8'h00 |=> xfer_halt && chk_cond && !rcv_req)
        else $error("zero retry did not halt");
    a_level_cap: assert property (
        rcv_req |-> rcv_level != 4'h0 && rcv_level <= (wr_q ? 4'h5 : 4'hc))
        else $error("recovery level out of range");
    a_step_limit: assert property (
        rcv_req |-> $past(cmd_rcv_ms, 2) < lim_q)
        else $error("step issued past command limit");
    a_realloc_gate: assert property (
        realloc_req |-> (wr_q ? auto_write_reallocate_en_q : (auto_read_reallocate_en_q && !rc_q)) && $past(cmd_rcv_ms) < lim_q)
        else $error("reallocation not allowed");
    a_list_grows: assert property (
        rp && realloc_done && !cmd_start |=> gl_count == $past(gl_count) + 1)
        else $error("grown list not appended");
    a_timer_idle: assert property (
        (blk_ready || rp) && !cmd_start |=> $stable(cmd_rcv_ms))
        else $error("timer ran outside recovery");
    a_timer_restart: assert property (
        cmd_start |=> cmd_rcv_ms == 16'h0000)
        else $error("timer not restarted");
    a_factory_frozen: assert property (
        factory_locked |=> factory_locked && $stable(pl_count))
        else $error("factory list changed after lock");
    a_halt_flags: assert property (
        $rose(xfer_halt) |-> chk_cond && err_unrec_write == wr_q && err_unrec_read == !wr_q)
        else $error("halt flags wrong");
endmodule

//--- tb/erp_media_model.sv
// media engine stand-in answering recovery steps and reallocations
// assumes single-cycle request pulses from erp_ctrl on mclk
`timescale 1ns/1ps
module erp_media_model (
    // clock and reset
    input wire mclk,
    input wire rst_b,
    // requests
    input wire rcv_req,
    input wire [3:0] rcv_level,
    input wire rcv_abort,
    input wire realloc_req,
    // knobs: levels up to fail_n fail, answers take step_delay cycles
    input wire [3:0] fail_n,
    input wire [15:0] step_delay,
    // answers
    output reg rcv_done,
    output reg rcv_ok,
    output reg realloc_done
);
    reg busy, rbusy;
    reg [3:0] lvl;
    reg [15:0] cnt, rcnt;
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            {busy, rbusy, lvl, cnt, rcnt, rcv_done, rcv_ok, realloc_done} <= 0;
        end else begin
            rcv_done <= 1'b0;
            realloc_done <= 1'b0;
            // junk outside a done pulse so a stale ok can never pass
            rcv_ok <= ~rcv_ok;
            if (rcv_abort) begin
                busy <= 1'b0;
            end else if (rcv_req) begin
                busy <= 1'b1;
                lvl <= rcv_level;
                cnt <= step_delay;
            end else if (busy && cnt <= 16'h0001) begin
                busy <= 1'b0;
                rcv_done <= 1'b1;
                rcv_ok <= lvl > fail_n;
            end else if (busy) begin
                cnt <= cnt - 16'h0001;
            end
            if (realloc_req) begin
                rbusy <= 1'b1;
                rcnt <= step_delay;
            end else if (rbusy && rcnt <= 16'h0001) begin
                rbusy <= 1'b0;
                realloc_done <= 1'b1;
            end else if (rbusy) begin
                rcnt <= rcnt - 16'h0001;
            end
        end
    end
endmodule

//--- tb/tb_top.sv
// self-checking bench for erp_ctrl with a media engine model
// assumes shortened timers: 20 cycles a millisecond, 4 a tenth
`timescale 1ns/1ps
module tb_top;
    logic mclk, rst_b, auto_read_reallocate_en, auto_write_reallocate_en, read_continuous;
    logic cmd_start, cmd_is_write, cmd_end, blk_valid, blk_error, blk_ready, blk_pass;
    logic rcv_req, rcv_abort, rcv_done, rcv_ok, realloc_req, realloc_done, xfer_halt, chk_cond;
    logic err_unrec_read, err_unrec_write, factory_defect_table_wr, factory_fmt_done, factory_locked;
    logic dl_start, dl_busy, dl_valid, dl_grown, dl_done;
    logic [7:0] read_retry_cnt, write_retry_cnt;
    logic [15:0] recovery_time_limit, cmd_rcv_ms, step_delay;
    logic [31:0] blk_addr, blk_pass_addr, realloc_addr, factory_defect_table_addr, dl_data, gaddr;
    logic [3:0] rcv_level, fail_n;
    logic [4:0] pl_count, gl_count;
    logic [32:0] de;
    logic [31:0] pass_q[$];
    logic [32:0] dl_q[$];
    int fails = 0, checks_done = 0, seed = 61, steps = 0;
    erp_ctrl #(.MS_CYC(20), .TENTH_CYC(4)) i_erp_ctrl (.*);
    erp_media_model i_erp_media_model (.*);
    initial begin
        mclk = 0;
        forever #2 mclk = ~mclk;
    end
    task automatic tally_and_finish;
        if (fails == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cmp_addr(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (e !== g) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_num(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (e !== g) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // bounded wait: 0 ready, 1 halt, 2 done
    task automatic wait_hi(input int b);
        int k;
        k = 0;
        while ((b == 0 ? blk_ready : b == 1 ? xfer_halt : dl_done) !== 1'b1 && k < 20000) begin
            @(negedge mclk);
            k++;
        end
        if (k == 20000) begin
            cmp_num("wait", 16'h0001, 16'h0000);
            tally_and_finish();
        end
    endtask
    task automatic cmd(input logic wr, input logic rc, input logic [7:0] rt, input logic [15:0] lim);
        cmd_is_write = wr;
        read_continuous = rc;
        read_retry_cnt = rt;
        write_retry_cnt = rt;
        recovery_time_limit = lim;
        cmd_start = 1;
        @(negedge mclk);
        cmd_start = 0;
    endtask
    task automatic end_cmd;
        repeat (2) @(negedge mclk);
        cmd_end = 1;
        @(negedge mclk);
        cmd_end = 0;
    endtask
    // valid held across blocks, dropped after the last
    task automatic send_n(input int n, input logic err, input logic ok);
        for (int i = 0; i < n; i++) begin
            wait_hi(0);
            blk_addr = $random(seed);
            gaddr = blk_addr;
            blk_error = err;
            blk_valid = 1;
            if (ok)
                pass_q.push_back(blk_addr);
            @(negedge mclk);
        end
        blk_valid = 0;
    endtask
    // one errored block that never recovers
    task automatic run_fail(input logic wr, input logic [7:0] rt, input logic [15:0] lim,
                            input logic [15:0] dly, input logic [15:0] n);
        fail_n = 4'hf;
        step_delay = dly;
        cmd(wr, 1'b0, rt, lim);
        steps = 0;
        send_n(1, 1'b1, 1'b0);
        wait_hi(1);
        repeat (2) @(negedge mclk);
        cmp_num("steps", n, steps[15:0]);
        cmp_num("halt_flags", {12'h001, 1'b1, !wr, wr}, {12'h000, xfer_halt, chk_cond, err_unrec_read, err_unrec_write});
        end_cmd();
    endtask
    always @(posedge mclk)
        if (rcv_req === 1'b1)
            steps <= steps + 1;
    always @(negedge mclk) begin
        if (blk_pass === 1'b1 && pass_q.size() == 0)
            cmp_num("extra_pass", 16'h0000, 16'h0001);
        else if (blk_pass === 1'b1)
            cmp_addr("blk_pass_addr", pass_q.pop_front(), blk_pass_addr);
        if (realloc_req === 1'b1)
            cmp_addr("realloc_addr", gaddr, realloc_addr);
        if (dl_valid === 1'b1) begin
            de = (dl_q.size() == 0) ? 33'h0 : dl_q.pop_front();
            cmp_addr("dl_data", de[31:0], dl_data);
            cmp_num("dl_grown", {15'h0000, de[32]}, {15'h0000, dl_grown});
        end
    end
    initial begin
        {rst_b, auto_read_reallocate_en, auto_write_reallocate_en, read_continuous, cmd_start} = 0;
        {cmd_is_write, cmd_end, blk_valid, blk_error, blk_addr, factory_defect_table_wr} = 0;
        {factory_defect_table_addr, factory_fmt_done, dl_start, recovery_time_limit, fail_n} = 0;
        read_retry_cnt = 8'h0c;
        write_retry_cnt = 8'h05;
        step_delay = 16'h0004;
        repeat (2) @(negedge mclk);
        rst_b = 1;
        @(negedge mclk);
        factory_defect_table_wr = 1;
        for (int i = 0; i < 3; i++) begin
            factory_defect_table_addr = $random(seed);
            dl_q.push_back({1'b0, factory_defect_table_addr});
            @(negedge mclk);
        end
        factory_defect_table_wr = 0;
        factory_fmt_done = 1;
        @(negedge mclk);
        factory_fmt_done = 0;
        factory_defect_table_wr = 1;
        @(negedge mclk);
        factory_defect_table_wr = 0;
        @(negedge mclk);
        cmp_num("pl_count", 16'h0003, {11'h000, pl_count});
        cmd(1'b0, 1'b0, 8'h0c, 16'h0000);
        send_n(4, 1'b0, 1'b1);
        end_cmd();
        auto_read_reallocate_en = 1;
        cmd(1'b0, 1'b1, 8'h0c, 16'h0000);
        send_n(2, 1'b1, 1'b1);
        repeat (2) @(negedge mclk);
        cmp_num("rc_flags", 16'h0000, {14'h0000, xfer_halt, chk_cond});
        end_cmd();
        fail_n = 4'h2;
        step_delay = 16'h0006;
        cmd(1'b0, 1'b0, 8'h0c, 16'h0000);
        steps = 0;
        send_n(1, 1'b1, 1'b1);
        dl_q.push_back({1'b1, gaddr});
        repeat (3) @(negedge mclk);
        wait_hi(0);
        cmp_num("steps", 16'h0003, steps[15:0]);
        cmp_num("gl_count", 16'h0001, {11'h000, gl_count});
        end_cmd();
        run_fail(1'b0, 8'h00, 16'h0000, 16'h0004, 16'h0000);
        run_fail(1'b1, 8'h05, 16'h0000, 16'h0004, 16'h0005);
        run_fail(1'b0, 8'h0c, 16'h0000, 16'h0004, 16'h000c);
        run_fail(1'b0, 8'h01, 16'h0000, 16'd1000, 16'h0005);
        run_fail(1'b1, 8'h01, 16'h0000, 16'd900, 16'h0004);
        run_fail(1'b0, 8'h0c, 16'h00c8, 16'd900, 16'h0005);
        run_fail(1'b1, 8'h05, 16'h0001, 16'd30, 16'h0001);
        dl_start = 1;
        @(negedge mclk);
        dl_start = 0;
        wait_hi(2);
        repeat (2) @(negedge mclk);
        cmp_num("dl_left", 16'h0000, dl_q.size());
        cmp_num("pass_left", 16'h0000, pass_q.size());
        cmp_num("ms", 16'h0001, cmd_rcv_ms);
        tally_and_finish();
    end
endmodule
bind erp_ctrl erp_props #(.ADDR_W(ADDR_W), .PL_AW(PL_AW), .GL_AW(GL_AW)) i_erp_props (
    .mclk, .rst_b, .auto_read_reallocate_en, .auto_write_reallocate_en, .read_continuous, .read_retry_cnt,
    .write_retry_cnt, .recovery_time_limit, .cmd_start, .cmd_is_write, .blk_valid, .blk_addr, .blk_error,
    .blk_ready, .blk_pass, .blk_pass_addr, .rcv_req, .rcv_level, .realloc_req, .realloc_done, .xfer_halt,
    .chk_cond, .err_unrec_read, .err_unrec_write, .cmd_rcv_ms, .factory_locked, .pl_count, .gl_count);
